// >>> ssd_pkg.sv
package ssd_pkg;

	// Word geometry.
	localparam int SSD_WORD_W = 32;
	localparam int SSD_DAC_W = 10;
	localparam int SSD_PCT_W = 7;
	localparam int SSD_SCALED_W = 17;
	localparam int SSD_STEP_W = 16;

	// Initial-setting word field positions.
	localparam int SSD_INIT_STALL_POS = 2;
	localparam int SSD_INIT_BOTTOM_LSB = 3;
	localparam int SSD_INIT_FREQ_LSB = 6;
	localparam int SSD_INIT_BOOST_LSB = 8;
	localparam int SSD_INIT_SENSE_POS = 12;
	localparam int SSD_INIT_GAIN_POS = 13;
	localparam logic [31:0] SSD_INIT_ZERO_MASK = 32'hFFFF_CC03;

	// Motor-control word field positions.
	localparam int SSD_MOT_TORQUE_LSB = 2;
	localparam int SSD_MOT_DECAY_A_LSB = 6;
	localparam int SSD_MOT_PHASE_A_POS = 8;
	localparam int SSD_MOT_DAC_A_LSB = 9;
	localparam int SSD_MOT_DECAY_B_LSB = 19;
	localparam int SSD_MOT_PHASE_B_POS = 21;
	localparam int SSD_MOT_DAC_B_LSB = 22;
	localparam logic [31:0] SSD_MOT_ZERO_MASK = 32'h0000_0023;

	// Values after reset.
	localparam logic [2:0] SSD_RST_TORQUE = 3'h0;
	localparam logic [1:0] SSD_RST_DECAY = 2'h0;
	localparam logic [9:0] SSD_RST_DAC = 10'h000;
	localparam logic [15:0] SSD_RST_STEP = 16'h0000;
	localparam logic [6:0] SSD_RST_PCT = 7'h64;

	// Decay codes and the oscillator periods of fast decay they select.
	localparam logic [1:0] SSD_DECAY_FAST_37 = 2'h0;
	localparam logic [1:0] SSD_DECAY_FAST_50 = 2'h1;
	localparam logic [1:0] SSD_DECAY_FAST_ONLY = 2'h2;
	localparam logic [1:0] SSD_DECAY_AUTO = 2'h3;
	localparam logic [4:0] SSD_FAST_PERIODS_37 = 5'h06;
	localparam logic [4:0] SSD_FAST_PERIODS_50 = 5'h08;
	localparam logic [4:0] SSD_FAST_PERIODS_ALL = 5'h10;
	localparam logic [4:0] SSD_FAST_PERIODS_AUTO = 5'h00;

	// Peak-current coefficients, in hundredths.
	localparam logic [7:0] SSD_COEF_NOSENSE_GAIN5 = 8'h9C;
	localparam logic [7:0] SSD_COEF_NOSENSE_GAIN10 = 8'h4E;
	localparam logic [7:0] SSD_COEF_EXT_GAIN5 = 8'h14;
	localparam logic [7:0] SSD_COEF_EXT_GAIN10 = 8'h0A;

	// Full-scale DAC value.
	localparam logic [9:0] SSD_DAC_FULL = 10'h3FF;

	// Pending-word state.
	typedef enum logic [2:0] {
		SSD_ST_IDLE = 3'b001,
		SSD_ST_PEND_INIT = 3'b010,
		SSD_ST_PEND_MOTOR = 3'b100
	} ssd_state_e;

endpackage

// >>> ssd_serial_decoder.sv
`timescale 1ns/10ps

module ssd_serial_decoder
	import ssd_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Mode selection.
	input wire logic if_sel_in,
	input wire logic bank_sel_in,
	// Received command word and latch.
	input wire logic word_valid_in,
	input wire logic [31:0] word_in,
	input wire logic latch_in,
	// Initial settings.
	output logic anti_stall_enable_out,
	output logic [2:0] bottom_limit_out,
	output logic [1:0] freq_limit_out,
	output logic [1:0] boost_out,
	output logic sense_mode_select_out,
	output logic gain_select_out,
	output logic resistorless_sensing_out,
	output logic [7:0] peak_coef_out,
	// Motor control.
	output logic outputs_enabled_out,
	output logic [2:0] torque_code_out,
	output logic [6:0] torque_pct_out,
	output logic [1:0] decay_code_a_out,
	output logic [1:0] decay_code_b_out,
	output logic [4:0] fast_periods_a_out,
	output logic [4:0] fast_periods_b_out,
	output logic auto_dynamic_decay_a_out,
	output logic auto_dynamic_decay_b_out,
	output logic phase_polarity_a_out,
	output logic phase_polarity_b_out,
	output logic [9:0] current_dac_value_a_out,
	output logic [9:0] current_dac_value_b_out,
	output logic [16:0] current_scaled_a_out,
	output logic [16:0] current_scaled_b_out,
	output logic [15:0] step_count_out,
	// Status.
	output logic pending_out,
	output logic word_reject_out
);

	function automatic logic [6:0] torque_pct(input logic [2:0] code);
		unique case (code)
			3'h0: torque_pct = 7'h64;
			3'h1: torque_pct = 7'h55;
			3'h2: torque_pct = 7'h46;
			3'h3: torque_pct = 7'h3c;
			3'h4: torque_pct = 7'h32;
			3'h5: torque_pct = 7'h28;
			3'h6: torque_pct = 7'h19;
			3'h7: torque_pct = 7'h0a;
		endcase
	endfunction

	function automatic logic [4:0] fast_periods(input logic [1:0] code);
		unique case (code)
			SSD_DECAY_FAST_37: fast_periods = SSD_FAST_PERIODS_37;
			SSD_DECAY_FAST_50: fast_periods = SSD_FAST_PERIODS_50;
			SSD_DECAY_FAST_ONLY: fast_periods = SSD_FAST_PERIODS_ALL;
			SSD_DECAY_AUTO: fast_periods = SSD_FAST_PERIODS_AUTO;
		endcase
	endfunction

	function automatic logic [16:0] scale(input logic [9:0] dac, input logic [6:0] pct);
		scale = 17'(dac * pct);
	endfunction

	// Reset release through two flip-flops.
	logic rst_meta_ff;
	logic rst_sync_ff;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	ssd_state_e state_ff, nxt_state;
	logic [31:0] pend_word_ff, nxt_pend_word;
	logic reject_ff, nxt_reject;

	logic stall_ff, nxt_stall;
	logic [2:0] bottom_ff, nxt_bottom;
	logic [1:0] freq_ff, nxt_freq;
	logic [1:0] boost_ff, nxt_boost;
	logic sense_ff, nxt_sense;
	logic gain_ff, nxt_gain;
	logic [7:0] coef_ff, nxt_coef;

	logic enabled_ff, nxt_enabled;
	logic [2:0] torque_ff, nxt_torque;
	logic [6:0] pct_ff, nxt_pct;
	logic [1:0] decay_ff [2];
	logic [1:0] nxt_decay [2];
	logic phase_ff [2];
	logic nxt_phase [2];
	logic [9:0] dac_ff [2];
	logic [9:0] nxt_dac [2];
	logic [16:0] scaled_ff [2];
	logic [16:0] nxt_scaled [2];
	logic [15:0] step_ff, nxt_step;

	logic word_ok;
	logic [6:0] new_pct;
	logic [7:0] new_coef;

	// Derived flags are registered from the next state so that every output is a flop.
	logic [4:0] periods_ff [2];
	logic [4:0] nxt_periods [2];
	logic auto_ff [2];
	logic nxt_auto [2];
	logic resist_ff, nxt_resist;
	logic pend_ff, nxt_pend;

	always_comb begin
		nxt_state = state_ff;
		nxt_pend_word = pend_word_ff;
		nxt_reject = reject_ff;
		nxt_stall = stall_ff;
		nxt_bottom = bottom_ff;
		nxt_freq = freq_ff;
		nxt_boost = boost_ff;
		nxt_sense = sense_ff;
		nxt_gain = gain_ff;
		nxt_coef = coef_ff;
		nxt_enabled = enabled_ff;
		nxt_torque = torque_ff;
		nxt_pct = pct_ff;
		nxt_decay = decay_ff;
		nxt_phase = phase_ff;
		nxt_dac = dac_ff;
		nxt_scaled = scaled_ff;
		nxt_step = step_ff;
		new_pct = torque_pct(pend_word_ff[SSD_MOT_TORQUE_LSB +: 3]);
		new_coef = SSD_COEF_EXT_GAIN5;
		// A word applied at the latch goes live as a whole, never in part.
		if (latch_in) begin
			unique case (state_ff)
				SSD_ST_PEND_INIT: begin
					nxt_stall = pend_word_ff[SSD_INIT_STALL_POS];
					nxt_bottom = pend_word_ff[SSD_INIT_BOTTOM_LSB +: 3];
					nxt_freq = pend_word_ff[SSD_INIT_FREQ_LSB +: 2];
					nxt_boost = pend_word_ff[SSD_INIT_BOOST_LSB +: 2];
					nxt_sense = pend_word_ff[SSD_INIT_SENSE_POS];
					nxt_gain = pend_word_ff[SSD_INIT_GAIN_POS];
					unique case ({pend_word_ff[SSD_INIT_SENSE_POS], pend_word_ff[SSD_INIT_GAIN_POS]})
						2'b00: new_coef = SSD_COEF_NOSENSE_GAIN5;
						2'b01: new_coef = SSD_COEF_NOSENSE_GAIN10;
						2'b10: new_coef = SSD_COEF_EXT_GAIN5;
						2'b11: new_coef = SSD_COEF_EXT_GAIN10;
					endcase
					nxt_coef = new_coef;
					nxt_state = SSD_ST_IDLE;
				end
				SSD_ST_PEND_MOTOR: begin
					// The old current stands until this point.
					nxt_torque = pend_word_ff[SSD_MOT_TORQUE_LSB +: 3];
					nxt_pct = new_pct;
					nxt_decay[0] = pend_word_ff[SSD_MOT_DECAY_A_LSB +: 2];
					nxt_decay[1] = pend_word_ff[SSD_MOT_DECAY_B_LSB +: 2];
					nxt_phase[0] = pend_word_ff[SSD_MOT_PHASE_A_POS];
					nxt_phase[1] = pend_word_ff[SSD_MOT_PHASE_B_POS];
					nxt_dac[0] = pend_word_ff[SSD_MOT_DAC_A_LSB +: SSD_DAC_W];
					nxt_dac[1] = pend_word_ff[SSD_MOT_DAC_B_LSB +: SSD_DAC_W];
					nxt_scaled[0] = scale(pend_word_ff[SSD_MOT_DAC_A_LSB +: SSD_DAC_W], new_pct);
					nxt_scaled[1] = scale(pend_word_ff[SSD_MOT_DAC_B_LSB +: SSD_DAC_W], new_pct);
					nxt_step = step_ff + 16'h0001;
					nxt_enabled = 1'b1;
					nxt_state = SSD_ST_IDLE;
				end
				default: nxt_state = SSD_ST_IDLE;
			endcase
		end
		// A word arriving with the latch waits for the next latch.
		if (word_valid_in && if_sel_in) begin
			if (bank_sel_in) begin
				word_ok = (word_in & SSD_MOT_ZERO_MASK) == 32'h0000_0000;
			end else begin
				word_ok = (word_in & SSD_INIT_ZERO_MASK) == 32'h0000_0000;
			end
			nxt_reject = !word_ok;
			if (word_ok) begin
				nxt_pend_word = word_in;
				nxt_state = bank_sel_in ? SSD_ST_PEND_MOTOR : SSD_ST_PEND_INIT;
			end
		end else begin
			word_ok = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff <= SSD_ST_IDLE;
			pend_word_ff <= 32'h0000_0000;
			reject_ff <= 1'b0;
			stall_ff <= 1'b0;
			bottom_ff <= 3'h0;
			freq_ff <= 2'h0;
			boost_ff <= 2'h0;
			sense_ff <= 1'b0;
			gain_ff <= 1'b0;
			coef_ff <= SSD_COEF_NOSENSE_GAIN5;
			enabled_ff <= 1'b0;
			torque_ff <= SSD_RST_TORQUE;
			pct_ff <= SSD_RST_PCT;
			for (int i = 0; i < 2; i++) begin
				decay_ff[i] <= SSD_RST_DECAY;
				phase_ff[i] <= 1'b0;
				dac_ff[i] <= SSD_RST_DAC;
				scaled_ff[i] <= 17'h0_0000;
			end
			step_ff <= SSD_RST_STEP;
		end else begin
			state_ff <= nxt_state;
			pend_word_ff <= nxt_pend_word;
			reject_ff <= nxt_reject;
			stall_ff <= nxt_stall;
			bottom_ff <= nxt_bottom;
			freq_ff <= nxt_freq;
			boost_ff <= nxt_boost;
			sense_ff <= nxt_sense;
			gain_ff <= nxt_gain;
			coef_ff <= nxt_coef;
			enabled_ff <= nxt_enabled;
			torque_ff <= nxt_torque;
			pct_ff <= nxt_pct;
			decay_ff <= nxt_decay;
			phase_ff <= nxt_phase;
			dac_ff <= nxt_dac;
			scaled_ff <= nxt_scaled;
			step_ff <= nxt_step;
		end
	end

	assign anti_stall_enable_out = stall_ff;
	assign bottom_limit_out = bottom_ff;
	assign freq_limit_out = freq_ff;
	assign boost_out = boost_ff;
	assign sense_mode_select_out = sense_ff;
	assign gain_select_out = gain_ff;
	assign resistorless_sensing_out = resist_ff;
	assign peak_coef_out = coef_ff;
	assign outputs_enabled_out = enabled_ff;
	assign torque_code_out = torque_ff;
	assign torque_pct_out = pct_ff;
	assign decay_code_a_out = decay_ff[0];
	assign decay_code_b_out = decay_ff[1];
	assign phase_polarity_a_out = phase_ff[0];
	assign phase_polarity_b_out = phase_ff[1];
	assign current_dac_value_a_out = dac_ff[0];
	assign current_dac_value_b_out = dac_ff[1];
	assign current_scaled_a_out = scaled_ff[0];
	assign current_scaled_b_out = scaled_ff[1];
	assign step_count_out = step_ff;
	assign pending_out = pend_ff;
	assign word_reject_out = reject_ff;

	// Decoded from the next codes, so they change in the same cycle as the codes.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			nxt_periods[i] = fast_periods(nxt_decay[i]);
			nxt_auto[i] = nxt_decay[i] == SSD_DECAY_AUTO;
		end
		nxt_resist = !nxt_sense;
		nxt_pend = nxt_state != SSD_ST_IDLE;
	end

	always_ff @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			for (int i = 0; i < 2; i++) begin
				periods_ff[i] <= SSD_FAST_PERIODS_37;
				auto_ff[i] <= 1'b0;
			end
			resist_ff <= 1'b1;
			pend_ff <= 1'b0;
		end else begin
			periods_ff <= nxt_periods;
			auto_ff <= nxt_auto;
			resist_ff <= nxt_resist;
			pend_ff <= nxt_pend;
		end
	end

	assign fast_periods_a_out = periods_ff[0];
	assign fast_periods_b_out = periods_ff[1];
	assign auto_dynamic_decay_a_out = auto_ff[0];
	assign auto_dynamic_decay_b_out = auto_ff[1];

endmodule

// >>> ssd_serial_decoder_chk.sv
`timescale 1ns/10ps
module ssd_serial_decoder_chk
	import ssd_pkg::*;
(
	// Watched ports.
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic if_sel_in,
	input wire logic bank_sel_in,
	input wire logic word_valid_in,
	input wire logic [31:0] word_in,
	input wire logic latch_in,
	input wire logic pending_out,
	input wire logic word_reject_out,
	input wire logic sense_mode_select_out,
	input wire logic resistorless_sensing_out,
	input wire logic [1:0] decay_code_a_out,
	input wire logic auto_dynamic_decay_a_out,
	input wire logic [6:0] torque_pct_out,
	input wire logic [9:0] current_dac_value_a_out,
	input wire logic [16:0] current_scaled_a_out,
	input wire logic [15:0] step_count_out
);
	logic take;
	logic bad_bits;
	assign take = word_valid_in && if_sel_in;
	assign bad_bits = |(word_in & (bank_sel_in ? SSD_MOT_ZERO_MASK : SSD_INIT_ZERO_MASK));
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	a_word_pend: assert property (take && !bad_bits |=> pending_out)
		else $error("good word not pending");
	a_word_rej: assert property (take && bad_bits |=> word_reject_out)
		else $error("bad word not rejected");
	a_ignore_off: assert property (!if_sel_in && !latch_in |=> $stable(pending_out) && $stable(word_reject_out))
		else $error("word taken while serial mode off");
	a_hold_dac: assert property (!latch_in |=> $stable(current_dac_value_a_out))
		else $error("current changed without latch");
	a_step_one: assert property (1'b1 |=> (step_count_out - $past(step_count_out)) <= 16'h0001)
		else $error("step advanced by more than one");
	a_lat_step: assert property (latch_in && pending_out && bank_sel_in && !word_valid_in
		|=> step_count_out == $past(step_count_out) + 16'h0001)
		else $error("applied motor word did not step");
	a_pend_clr: assert property (latch_in && !word_valid_in |=> !pending_out)
		else $error("pending kept after latch");
	a_auto_dec: assert property (auto_dynamic_decay_a_out == (decay_code_a_out == 2'h3))
		else $error("auto decay flag wrong");
	a_sense_inv: assert property (resistorless_sensing_out != sense_mode_select_out)
		else $error("sensing mode flag wrong");
	a_scaled: assert property (current_scaled_a_out == 17'(current_dac_value_a_out) * 17'(torque_pct_out))
		else $error("scaled current wrong");
	c_apply: cover property (latch_in && pending_out);
	c_reject: cover property ($rose(word_reject_out));
	c_ignore: cover property (!if_sel_in && word_valid_in);
endmodule

// >>> ssd_host_model.sv
`timescale 1ns/10ps
module ssd_host_model (
	// Clock.
	input wire logic clk_in,
	// Command lines toward the decoder.
	output logic bank_sel_out,
	output logic word_valid_out,
	output logic [31:0] word_out,
	output logic latch_out
);
	localparam logic [31:0] fs_words[4] = '{32'hFFE7_FF00, 32'hFFE7_FE00, 32'hFFC7_FE00, 32'hFFC7_FF00};
	initial begin
		bank_sel_out = 1'b0;
		word_valid_out = 1'b0;
		word_out = 32'h0000_0000;
		latch_out = 1'b0;
	end
	// Bank select keeps its level until the next word, so it stands through the latch.
	task automatic send(input logic b, input logic [31:0] w);
		@(posedge clk_in);
		#1;
		bank_sel_out = b;
		word_out = w;
		word_valid_out = 1'b1;
		@(posedge clk_in);
		#1;
		word_valid_out = 1'b0;
		word_out = ~w;
	endtask
	task automatic lat;
		latch_out = 1'b1;
		@(posedge clk_in);
		#1;
		latch_out = 1'b0;
	endtask
	task automatic step_cmd(input int k);
		send(1'b1, fs_words[k]);
		lat();
	endtask
endmodule

// >>> test_stepper_serial_command_decoder.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module test_stepper_serial_command_decoder;
	logic clk_in, rst_b_in, if_sel_in, bank_sel_in, word_valid_in, latch_in;
	logic [31:0] word_in;
	logic anti_stall_enable_out, sense_mode_select_out, gain_select_out, resistorless_sensing_out;
	logic outputs_enabled_out, auto_dynamic_decay_a_out, auto_dynamic_decay_b_out;
	logic phase_polarity_a_out, phase_polarity_b_out, pending_out, word_reject_out;
	logic [1:0] freq_limit_out, boost_out, decay_code_a_out, decay_code_b_out;
	logic [2:0] bottom_limit_out, torque_code_out;
	logic [4:0] fast_periods_a_out, fast_periods_b_out;
	logic [6:0] torque_pct_out;
	logic [7:0] peak_coef_out;
	logic [9:0] current_dac_value_a_out, current_dac_value_b_out;
	logic [16:0] current_scaled_a_out, current_scaled_b_out;
	logic [15:0] step_count_out, exp_step;
	int bad_count = 0;
	int n_tests = 0;
	localparam logic [6:0] pct_tab[8] = '{7'h64, 7'h55, 7'h46, 7'h3C, 7'h32, 7'h28, 7'h19, 7'h0A};
	localparam logic [4:0] fp_tab[4] = '{5'h06, 5'h08, 5'h10, 5'h00};
	localparam logic [7:0] cf_tab[4] = '{8'h9C, 8'h14, 8'h4E, 8'h0A};
	localparam logic [1:0] ph_tab[4] = '{2'b11, 2'b01, 2'b00, 2'b10};
	ssd_serial_decoder u_dut (.clk_in, .rst_b_in, .if_sel_in, .bank_sel_in, .word_valid_in, .word_in,
		.latch_in, .anti_stall_enable_out, .bottom_limit_out, .freq_limit_out, .boost_out,
		.sense_mode_select_out, .gain_select_out, .resistorless_sensing_out, .peak_coef_out,
		.outputs_enabled_out, .torque_code_out, .torque_pct_out, .decay_code_a_out, .decay_code_b_out,
		.fast_periods_a_out, .fast_periods_b_out, .auto_dynamic_decay_a_out, .auto_dynamic_decay_b_out,
		.phase_polarity_a_out, .phase_polarity_b_out, .current_dac_value_a_out, .current_dac_value_b_out,
		.current_scaled_a_out, .current_scaled_b_out, .step_count_out, .pending_out, .word_reject_out);
	ssd_host_model u_host (.clk_in, .bank_sel_out(bank_sel_in), .word_valid_out(word_valid_in),
		.word_out(word_in), .latch_out(latch_in));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task tick;
		@(posedge clk_in);
		#1;
	endtask
	task t_init;
		logic [31:0] w;
		for (int i = 0; i < 4; i++) begin
			w = {18'h0, i[1], i[0], 2'h0, 2'h3, 2'h2, 3'h5, 1'b1, 2'h0};
			u_host.send(1'b0, w);
			`CHK({pending_out, anti_stall_enable_out}, {1'b1, i != 0});
			u_host.lat();
			tick();
			`CHK({boost_out, freq_limit_out, bottom_limit_out, anti_stall_enable_out}, w[9:2]);
			`CHK({gain_select_out, sense_mode_select_out, pending_out, outputs_enabled_out}, {w[13:12], 2'b00});
			`CHK({peak_coef_out, resistorless_sensing_out}, {cf_tab[i], ~w[12]});
		end
	endtask
	task t_full;
		for (int k = 0; k < 4; k++) begin
			u_host.step_cmd(k);
			tick();
			exp_step++;
			`CHK({phase_polarity_a_out, phase_polarity_b_out}, ph_tab[k]);
			`CHK({current_dac_value_a_out, outputs_enabled_out}, {10'h3ff, 1'b1});
			`CHK(step_count_out, exp_step);
		end
	endtask
	task t_motor;
		logic [31:0] w;
		logic [2:0] t;
		for (int i = 0; i < 8; i++) begin
			t = 3'(i);
			w = {10'(i * 7 + 1), t[1], ~t[1:0], 10'h3FF ^ 10'(i), t[0], t[1:0], 1'b0, t, 2'b00};
			u_host.send(1'b1, w);
			u_host.lat();
			tick();
			exp_step++;
			`CHK({current_dac_value_b_out, phase_polarity_b_out, decay_code_b_out}, w[31:19]);
			`CHK({current_dac_value_a_out, phase_polarity_a_out}, w[18:8]);
			`CHK({decay_code_a_out, torque_code_out}, {w[7:6], w[4:2]});
			`CHK(torque_pct_out, pct_tab[i]);
			`CHK({fast_periods_a_out, fast_periods_b_out}, {fp_tab[t[1:0]], fp_tab[~t[1:0]]});
			`CHK({auto_dynamic_decay_a_out, auto_dynamic_decay_b_out}, {t[1:0] == 2'h3, t[1:0] == 2'h0});
			`CHK(current_scaled_b_out, 17'(i * 7 + 1) * 17'(pct_tab[i]));
			`CHK(step_count_out, exp_step);
		end
	endtask
	task t_hold_reject;
		u_host.send(1'b1, 32'h0000_0200);
		`CHK({pending_out, current_dac_value_a_out}, {1'b1, 10'h3F8});
		u_host.send(1'b1, 32'h0000_0421);
		`CHK({word_reject_out, pending_out}, 2'b11);
		u_host.send(1'b0, 32'h8000_0000);
		`CHK({word_reject_out, pending_out}, 2'b11);
		u_host.send(1'b1, 32'h0000_0400);
		u_host.lat();
		tick();
		exp_step++;
		`CHK({current_dac_value_a_out, step_count_out, word_reject_out}, {10'h002, exp_step, 1'b0});
		u_host.lat();
		tick();
		`CHK({pending_out, step_count_out}, {1'b0, exp_step});
		if_sel_in = 1'b0;
		u_host.send(1'b1, 32'h0000_0200);
		u_host.lat();
		tick();
		`CHK({pending_out, step_count_out, current_dac_value_a_out}, {1'b0, exp_step, 10'h002});
		if_sel_in = 1'b1;
	endtask
	initial begin
		exp_step = 16'h0000;
		if_sel_in = 1'b1;
		rst_b_in = 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
		rst_b_in = 1'b1;
		repeat (3) tick();
		`CHK({torque_pct_out, peak_coef_out, fast_periods_a_out}, {7'h64, 8'h9C, 5'h06});
		`CHK({step_count_out, pending_out, resistorless_sensing_out}, {16'h0000, 1'b0, 1'b1});
		t_init();
		t_full();
		t_motor();
		t_hold_reject();
		report_and_stop();
	end
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
endmodule
bind ssd_serial_decoder ssd_serial_decoder_chk u_chk (.clk_in, .rst_b_in, .if_sel_in, .bank_sel_in,
	.word_valid_in, .word_in, .latch_in, .pending_out, .word_reject_out, .sense_mode_select_out,
	.resistorless_sensing_out, .decay_code_a_out, .auto_dynamic_decay_a_out, .torque_pct_out,
	.current_dac_value_a_out, .current_scaled_a_out, .step_count_out);
